// ===== rtl/slmi_pkg.sv
// Purpose: Constants and types for the serial LAN media interface
// Assumes: One 10 MHz system clock, link clocks sampled as plain inputs
// Notes: Shared by the media interface top and its transmit buffer
//
// Notes on behaviour
// - In Ethernet mode ring driver pair sits at true high, complement low.
// - Serial transmit bits change in step with the transceiver transmit clock.
// - Wrap control high requests transceiver loopback, low is normal operation.
// - Collision input is accepted whether true collision or quality test pulse.
// - Transmit enable is high exactly while transmit data carries frame bits.
// - Network select LHH 16M ring, HLH Ethernet, HHH 4M ring, rest reserved.
// - Test pins b and c low: outputs float, input pullups off except test.
// - External fail blocks copy and flag setting, internal match still allowed.
// - External match copies frame and sets recognized and copied bits.
// - Both checker inputs are ignored while copy all frames is enabled.
// - Marked inputs carry pullups holding an open pin high.
package slmi_pkg;
  localparam int SYNC_STAGES = 2;
  localparam int COLL_STAGES = 3;
  localparam int BYTE_BITS = 8;
  localparam logic [1:0] COLL_MIN_TICKS = 2'h2;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [1:0] RING_DRV_RESET = 2'h1;
  localparam logic [2:0] NSEL_RING16 = 3'h3;
  localparam logic [2:0] NSEL_ETH = 3'h5;
  localparam logic [2:0] NSEL_RING4 = 3'h7;
  localparam int BUF_DEPTH = 2;

  typedef enum logic [1:0] {SLMI_RING16, SLMI_ETH, SLMI_RING4, SLMI_RSVD} slmi_net_e;
  typedef enum logic [1:0] {SLMI_TX_IDLE, SLMI_TX_SEND, SLMI_TX_DRAIN} slmi_tx_e;

  // Decode of {select_0, select_1, select_2}
  function automatic slmi_net_e slmi_decode_net(input logic [2:0] sel);
    slmi_net_e m;
    m = SLMI_RSVD;
    if (sel == NSEL_RING16) begin
      m = SLMI_RING16;
    end else if (sel == NSEL_ETH) begin
      m = SLMI_ETH;
    end else if (sel == NSEL_RING4) begin
      m = SLMI_RING4;
    end
    return m;
  endfunction
endpackage

// ===== rtl/slmi_buf_if.sv
`timescale 1ns/1ps
// Purpose: Valid/ready carrier between the top and its transmit buffer
// Assumes: Both sides on clk
// Notes: Word is byte plus end-of-frame flag
interface slmi_buf_if #(parameter int W = 9);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  modport buf_side (input in_valid, input in_data, input out_ready,
                    output in_ready, output out_valid, output out_data);
  modport user_side (output in_valid, output in_data, output out_ready,
                     input in_ready, input out_valid, input out_data);
endinterface

// ===== rtl/slmi_tx_buf.sv
`timescale 1ns/1ps
// Purpose: Two-entry transmit word buffer
// Assumes: Writer and reader on clk
// Notes: Full and empty follow the held count exactly
module slmi_tx_buf
  import slmi_pkg::*;
#(
  parameter int W = 9,
  parameter int DEPTH = slmi_pkg::BUF_DEPTH
) (
  input wire logic clk,
  input wire logic rstn,
  slmi_buf_if.buf_side b
);
  logic [W-1:0] mem_r [DEPTH];
  logic [W-1:0] mem_nxt [DEPTH];
  logic [$clog2(DEPTH)-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [$clog2(DEPTH):0] cnt_r, cnt_nxt;
  logic push, pop;

  assign b.in_ready = (cnt_r != DEPTH[$clog2(DEPTH):0]);
  assign b.out_valid = (cnt_r != '0);
  assign b.out_data = mem_r[rp_r];
  assign push = b.in_valid && b.in_ready;
  assign pop = b.out_valid && b.out_ready;

  always_comb begin
    mem_nxt = mem_r;
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    if (push) begin
      mem_nxt[wp_r] = b.in_data;
      wp_nxt = (wp_r == $clog2(DEPTH)'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
    end
    if (pop) begin
      rp_nxt = (rp_r == $clog2(DEPTH)'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mem_r <= '{default: '0};
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      mem_r <= mem_nxt;
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  buf_bound_a: assert property (@(posedge clk) disable iff (!rstn)
    cnt_r <= DEPTH[$clog2(DEPTH):0]) else $error("buffer count over depth");
endmodule

// ===== rtl/slmi_top.sv
`timescale 1ns/1ps
// Purpose: Ethernet-mode serial media interface toward a serial transceiver
// Assumes: Link clocks much slower than clk, sampled and edge detected
// Notes: Transmit bytes go LSB first; data changes after each transmit clock rise
module slmi_top
  import slmi_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic tx_bit_clock_in,
  input wire logic rx_bit_clock_in,
  input wire logic serial_rx_bit_in,
  input wire logic carrier_present_in,
  input wire logic collision_in,
  input wire logic net_select_0,
  input wire logic net_select_1,
  input wire logic net_select_2,
  input wire logic board_test_pin_a,
  input wire logic board_test_pin_b,
  input wire logic board_test_pin_c,
  input wire logic ext_addr_nomatch_in,
  input wire logic ext_addr_match_in,
  input wire logic [slmi_pkg::BYTE_BITS-1:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic wrap_req,
  input wire logic copy_all_frames_mode,
  input wire logic int_addr_match,
  output logic [slmi_pkg::BYTE_BITS-1:0] rx_data,
  output logic rx_valid,
  output logic rx_frame_end,
  output logic copy_frame,
  output logic addr_recognized_frame_copied_bits,
  output logic collision_seen,
  output slmi_pkg::slmi_net_e net_mode,
  output logic serial_tx_bit_out,
  output logic serial_tx_bit_oe,
  output logic tx_valid_out,
  output logic tx_valid_oe,
  output logic front_end_wrap_ctl,
  output logic front_end_wrap_oe,
  output logic [1:0] ring_diff_driver_out,
  output logic ring_diff_driver_oe,
  output logic input_pullup_en,
  output logic test_pullup_en
);
  import slmi_pkg::*;

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  localparam int NS = 11;
  logic [NS-1:0] pin_raw, pin_s;
  logic [NS-1:0] sync_r [SYNC_STAGES];
  logic [COLL_STAGES-1:0] coll_r;
  logic txc_d_r, rxc_d_r;

  assign pin_raw = {tx_bit_clock_in, rx_bit_clock_in, serial_rx_bit_in, carrier_present_in,
                    net_select_0, net_select_1, net_select_2, board_test_pin_b, board_test_pin_c,
                    ext_addr_nomatch_in, ext_addr_match_in};
  assign pin_s = sync_r[SYNC_STAGES-1];

  wire txc_s = pin_s[10];
  wire rxc_s = pin_s[9];
  wire rxd_s = pin_s[8];
  wire crs_s = pin_s[7];
  wire [2:0] nsel_s = pin_s[6:4];
  wire mip_s = !pin_s[3] && !pin_s[2];
  wire nomatch_s = pin_s[1];
  wire match_s = pin_s[0];
  wire coll_s = coll_r[COLL_STAGES-1];
  wire tx_tick = txc_s && !txc_d_r;
  wire rx_tick = rxc_s && !rxc_d_r;

  // Slow link clocks only: edges are found by sampling, not by clocking on them
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync_r <= '{default: '0};
      coll_r <= '0;
      txc_d_r <= 1'b0;
      rxc_d_r <= 1'b0;
    end else begin
      sync_r[0] <= pin_raw;
      for (int i = 1; i < SYNC_STAGES; i++) begin
        sync_r[i] <= sync_r[i-1];
      end
      coll_r <= {coll_r[COLL_STAGES-2:0], collision_in};
      txc_d_r <= txc_s;
      rxc_d_r <= rxc_s;
    end
  end

  // ************************************************************
  // Network select strap and pin control
  // ************************************************************
  logic [1:0] settle_r, settle_nxt;
  slmi_net_e net_r, net_nxt;
  logic eth;

  // Strap taken once after the synchronisers fill; later changes are not followed
  always_comb begin
    settle_nxt = settle_r;
    net_nxt = net_r;
    if (settle_r != STRAP_SETTLE) begin
      settle_nxt = settle_r + 1'b1;
      net_nxt = slmi_decode_net(nsel_s);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      settle_r <= '0;
      net_r <= SLMI_RSVD;
    end else begin
      settle_r <= settle_nxt;
      net_r <= net_nxt;
    end
  end

  assign net_mode = net_r;
  assign eth = (net_r == SLMI_ETH);
  assign ring_diff_driver_out = RING_DRV_RESET;
  assign front_end_wrap_ctl = wrap_req;
  assign ring_diff_driver_oe = !mip_s;
  assign serial_tx_bit_oe = !mip_s;
  assign tx_valid_oe = !mip_s;
  assign front_end_wrap_oe = !mip_s;
  assign input_pullup_en = !mip_s;
  assign test_pullup_en = 1'b1;

  // ************************************************************
  // Transmit path
  // ************************************************************
  slmi_buf_if #(.W(BYTE_BITS + 1)) txb ();
  slmi_tx_buf #(.W(BYTE_BITS + 1), .DEPTH(BUF_DEPTH)) u_buf (
    .clk(clk),
    .rstn(rstn),
    .b(txb.buf_side)
  );

  slmi_tx_e tst_r, tst_nxt;
  logic [BYTE_BITS-1:0] sh_r, sh_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic last_r, last_nxt, ten_r, ten_nxt, txd_r, txd_nxt;
  logic [1:0] ccnt_r, ccnt_nxt;
  logic cseen_r, cseen_nxt;
  logic pop, coll_ok;

  assign txb.in_valid = tx_valid;
  assign txb.in_data = {tx_last, tx_data};
  assign tx_ready = txb.in_ready;
  assign txb.out_ready = pop;
  assign coll_ok = tx_tick && coll_s && (ccnt_r == COLL_MIN_TICKS - 2'h1);

  always_comb begin
    tst_nxt = tst_r;
    sh_nxt = sh_r;
    bit_nxt = bit_r;
    last_nxt = last_r;
    ten_nxt = ten_r;
    txd_nxt = txd_r;
    ccnt_nxt = ccnt_r;
    cseen_nxt = 1'b0;
    pop = 1'b0;
    if (tx_tick) begin
      // Any high level counts: collision or quality test pulse alike
      ccnt_nxt = coll_s ? ((ccnt_r == COLL_MIN_TICKS) ? ccnt_r : ccnt_r + 1'b1) : 2'h0;
      cseen_nxt = coll_ok;
    end
    case (tst_r)
      SLMI_TX_IDLE: begin
        if (tx_tick && txb.out_valid && eth && !mip_s) begin
          pop = 1'b1;
          {last_nxt, sh_nxt} = txb.out_data;
          bit_nxt = '0;
          txd_nxt = txb.out_data[0];
          ten_nxt = 1'b1;
          tst_nxt = SLMI_TX_SEND;
        end
      end
      SLMI_TX_SEND: begin
        if (coll_ok) begin
          ten_nxt = 1'b0;
          txd_nxt = 1'b0;
          tst_nxt = last_r ? SLMI_TX_IDLE : SLMI_TX_DRAIN;
        end else if (tx_tick && bit_r != BIT_LAST) begin
          bit_nxt = bit_r + 1'b1;
          sh_nxt = sh_r >> 1;
          txd_nxt = sh_r[1];
        end else if (tx_tick && !last_r && txb.out_valid) begin
          pop = 1'b1;
          {last_nxt, sh_nxt} = txb.out_data;
          bit_nxt = '0;
          txd_nxt = txb.out_data[0];
        end else if (tx_tick) begin
          // Underrun truncates the frame rather than sending stale bits
          ten_nxt = 1'b0;
          txd_nxt = 1'b0;
          tst_nxt = last_r ? SLMI_TX_IDLE : SLMI_TX_DRAIN;
        end
      end
      default: begin
        if (txb.out_valid) begin
          pop = 1'b1;
          if (txb.out_data[BYTE_BITS]) begin
            tst_nxt = SLMI_TX_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tst_r <= SLMI_TX_IDLE;
      sh_r <= '0;
      bit_r <= '0;
      last_r <= 1'b0;
      ten_r <= 1'b0;
      txd_r <= 1'b0;
      ccnt_r <= '0;
      cseen_r <= 1'b0;
    end else begin
      tst_r <= tst_nxt;
      sh_r <= sh_nxt;
      bit_r <= bit_nxt;
      last_r <= last_nxt;
      ten_r <= ten_nxt;
      txd_r <= txd_nxt;
      ccnt_r <= ccnt_nxt;
      cseen_r <= cseen_nxt;
    end
  end

  assign serial_tx_bit_out = txd_r;
  assign tx_valid_out = ten_r;
  assign collision_seen = cseen_r;

  // ************************************************************
  // Receive path and copy decision
  // ************************************************************
  logic [BYTE_BITS-1:0] rsh_r, rsh_nxt, rdat_r, rdat_nxt;
  logic [2:0] rcnt_r, rcnt_nxt;
  logic rv_r, rv_nxt, rend_r, rend_nxt, crs_d_r, crs_d_nxt;
  logic xm_r, xm_nxt, xf_r, xf_nxt, cp_r, cp_nxt, ar_r, ar_nxt;

  always_comb begin
    rsh_nxt = rsh_r;
    rdat_nxt = rdat_r;
    rcnt_nxt = rcnt_r;
    rv_nxt = 1'b0;
    rend_nxt = 1'b0;
    crs_d_nxt = crs_s;
    xm_nxt = xm_r;
    xf_nxt = xf_r;
    cp_nxt = cp_r;
    ar_nxt = ar_r;
    if (crs_s && eth) begin
      if (!crs_d_r) begin
        rcnt_nxt = '0;
        xm_nxt = 1'b0;
        xf_nxt = 1'b0;
      end else begin
        xm_nxt = xm_r || (match_s && !nomatch_s);
        xf_nxt = xf_r || (nomatch_s && !match_s);
      end
      if (rx_tick) begin
        rsh_nxt = {rxd_s, rsh_r[BYTE_BITS-1:1]};
        rcnt_nxt = rcnt_r + 1'b1;
        if (rcnt_r == BIT_LAST) begin
          rdat_nxt = {rxd_s, rsh_r[BYTE_BITS-1:1]};
          rv_nxt = 1'b1;
        end
      end
    end
    if (!crs_s && crs_d_r) begin
      rend_nxt = 1'b1;
      if (copy_all_frames_mode) begin
        cp_nxt = 1'b1;
        ar_nxt = int_addr_match;
      end else begin
        cp_nxt = int_addr_match || (xm_r && !xf_r);
        ar_nxt = int_addr_match || (xm_r && !xf_r);
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rsh_r <= '0;
      rdat_r <= '0;
      rcnt_r <= '0;
      rv_r <= 1'b0;
      rend_r <= 1'b0;
      crs_d_r <= 1'b0;
      xm_r <= 1'b0;
      xf_r <= 1'b0;
      cp_r <= 1'b0;
      ar_r <= 1'b0;
    end else begin
      rsh_r <= rsh_nxt;
      rdat_r <= rdat_nxt;
      rcnt_r <= rcnt_nxt;
      rv_r <= rv_nxt;
      rend_r <= rend_nxt;
      crs_d_r <= crs_d_nxt;
      xm_r <= xm_nxt;
      xf_r <= xf_nxt;
      cp_r <= cp_nxt;
      ar_r <= ar_nxt;
    end
  end

  assign rx_data = rdat_r;
  assign rx_valid = rv_r;
  assign rx_frame_end = rend_r;
  assign copy_frame = cp_r;
  assign addr_recognized_frame_copied_bits = ar_r;

  // ************************************************************
  // Checks
  // ************************************************************
  ring_drv_level_a: assert property (@(posedge clk) disable iff (!rstn)
    ring_diff_driver_out == 2'h1) else $error("ring driver pair not at reset levels");
  tx_bit_sync_a: assert property (@(posedge clk) disable iff (!rstn)
    $changed(serial_tx_bit_out) |-> $past(tx_tick)) else $error("tx bit moved off a tx clock edge");
  tx_enable_sync_a: assert property (@(posedge clk) disable iff (!rstn)
    $changed(tx_valid_out) |-> $past(tx_tick) || $past(coll_ok)) else $error("tx enable moved off edge");
  coll_accept_a: assert property (@(posedge clk) disable iff (!rstn)
    collision_seen |-> $past(coll_s) && $past(ccnt_r) == 2'h1) else $error("collision accepted too early");
  coll_abort_a: assert property (@(posedge clk) disable iff (!rstn)
    coll_ok && tst_r == SLMI_TX_SEND |=> !tx_valid_out) else $error("collision did not stop transmit");
  mip_float_a: assert property (@(posedge clk) disable iff (!rstn)
    mip_s |-> !serial_tx_bit_oe && !tx_valid_oe && !input_pullup_en && test_pullup_en)
    else $error("test mode left outputs driven");
  rx_on_edge_a: assert property (@(posedge clk) disable iff (!rstn)
    rx_valid |-> $past(rx_tick) && $past(crs_s)) else $error("rx byte without rx clock edge");
  nomatch_block_a: assert property (@(posedge clk) disable iff (!rstn)
    rend_nxt && !copy_all_frames_mode && xf_r && !int_addr_match |=> !copy_frame)
    else $error("frame copied despite checker fail");
  copy_all_a: assert property (@(posedge clk) disable iff (!rstn)
    rend_nxt && copy_all_frames_mode |=> copy_frame && addr_recognized_frame_copied_bits == $past(int_addr_match))
    else $error("checker inputs not ignored in copy all");
  wrap_follow_a: assert property (@(posedge clk) disable iff (!rstn)
    front_end_wrap_ctl == wrap_req) else $error("wrap control wrong");
endmodule

// ===== verification/slmi_xcvr_model.sv
`timescale 1ns/1ps
// Purpose: Behavioural serial transceiver facing the media interface
// Assumes: Transmit clock free running, receive clock only inside frames
// Notes: Frames and collisions are started by the bench through tasks
module slmi_xcvr_model (
  output logic tx_clk,
  output logic rx_clk,
  output logic rxd,
  output logic crs,
  output logic coll,
  input wire logic txd,
  input wire logic txen
);
  // ********************************
  // Clocks and capture
  // ********************************
  logic tx_bits[$];

  initial begin
    tx_clk = 1'b0;
    #137;
    forever #400 tx_clk = ~tx_clk;
  end

  initial begin
    rx_clk = 1'b0;
    rxd = 1'b0;
    crs = 1'b0;
    coll = 1'b0;
  end

  // Bits count only where enable marks them as frame data
  always @(posedge tx_clk) begin
    if (txen === 1'b1) tx_bits.push_back(txd);
  end

  // ********************************
  // Frame and collision tasks
  // ********************************
  task automatic send_frame(input logic [7:0] d);
    crs = 1'b1;
    repeat (4) #800;
    for (int i = 0; i < 8; i++) begin
      rxd = d[i];
      #400 rx_clk = 1'b1;
      #400 rx_clk = 1'b0;
    end
    crs = 1'b0;
    // Released line shows the inverse so a stale bit cannot pass; clock stays low
    rxd = ~rxd;
  endtask

  task automatic coll_pulse(input int n);
    @(posedge tx_clk);
    #100 coll = 1'b1;
    repeat (n) @(posedge tx_clk);
    #100 coll = 1'b0;
  endtask
endmodule

// ===== verification/serial_lan_media_interface_tb.sv
`timescale 1ns/1ps
// Purpose: Self-checking bench for the serial LAN media interface
// Assumes: Transceiver model supplies link clocks, frames and collisions
// Notes: Bench inputs change on the falling clk edge
module serial_lan_media_interface_tb;
  import slmi_pkg::*;
  // ********************************
  // Signals
  // ********************************
  logic clk, rstn, s0, s1, s2, tpb, tpc, nomatch, match, tx_last, tx_valid, wrap_req, cp_all, imatch;
  logic [7:0] tx_data, rx_data;
  logic txc, rxc, rxd, crs, coll, tx_ready, rx_valid, rx_frame_end, copy_frame, arfc, coll_seen;
  logic txd, txd_oe, txen, txen_oe, wrap, wrap_oe, ring_oe, in_pu, test_pu;
  logic [1:0] ring;
  slmi_net_e net_mode;
  int num_errors = 0, compares = 0, fe_cnt = 0, coll_cnt = 0, n, fe0, c0;
  logic [7:0] rxq[$];
  logic [15:0] got;
  logic [2:0] codes[4] = '{3'h3, 3'h7, 3'h1, 3'h5};
  logic [1:0] modes[4] = '{2'h0, 2'h2, 2'h3, 2'h1};
  // Copy all, internal, ext match, ext fail, expected copy, expected bits
  logic [5:0] cases[6] = '{6'h0b, 6'h0c, 6'h04, 6'h17, 6'h26, 6'h00};

  slmi_top DUT (
    .clk(clk), .rstn(rstn), .tx_bit_clock_in(txc), .rx_bit_clock_in(rxc), .serial_rx_bit_in(rxd),
    .carrier_present_in(crs), .collision_in(coll), .net_select_0(s0), .net_select_1(s1), .net_select_2(s2),
    .board_test_pin_a(1'b1), .board_test_pin_b(tpb), .board_test_pin_c(tpc), .ext_addr_nomatch_in(nomatch),
    .ext_addr_match_in(match), .tx_data(tx_data), .tx_last(tx_last), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .wrap_req(wrap_req), .copy_all_frames_mode(cp_all), .int_addr_match(imatch), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_frame_end(rx_frame_end), .copy_frame(copy_frame),
    .addr_recognized_frame_copied_bits(arfc), .collision_seen(coll_seen), .net_mode(net_mode),
    .serial_tx_bit_out(txd), .serial_tx_bit_oe(txd_oe), .tx_valid_out(txen), .tx_valid_oe(txen_oe),
    .front_end_wrap_ctl(wrap), .front_end_wrap_oe(wrap_oe), .ring_diff_driver_out(ring),
    .ring_diff_driver_oe(ring_oe), .input_pullup_en(in_pu), .test_pullup_en(test_pu)
  );
  slmi_xcvr_model xcvr (.tx_clk(txc), .rx_clk(rxc), .rxd(rxd), .crs(crs), .coll(coll), .txd(txd), .txen(txen));

  // ********************************
  // Tasks
  // ********************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic bound(input int lim);
    if (n >= lim) begin
      num_errors++;
      close_out;
    end
  endtask

  task automatic done(input string name);
    $display("test %s finished, mismatches %0d", name, num_errors);
  endtask

  task automatic do_reset(input logic [2:0] sel);
    @(negedge clk);
    rstn = 1'b0;
    {s0, s1, s2} = sel;
    repeat (12) @(negedge clk);
    chk(net_mode, SLMI_RSVD);
    rstn = 1'b1;
    repeat (6) @(negedge clk);
  endtask

  // Valid stays up between words; the caller drops it after the last one
  task automatic push(input logic [7:0] d, input logic last);
    tx_data = d;
    tx_last = last;
    tx_valid = 1'b1;
    for (n = 0; n < 4000 && tx_ready !== 1'b1; n++) @(negedge clk);
    bound(4000);
    @(negedge clk);
  endtask

  always @(posedge clk) begin
    if (rx_valid === 1'b1) rxq.push_back(rx_data);
    if (rx_frame_end === 1'b1) fe_cnt++;
    if (coll_seen === 1'b1) coll_cnt++;
  end

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    #9000000;
    num_errors++;
    close_out;
  end

  // ********************************
  // Sequence
  // ********************************
  initial begin
    rstn = 1'b0;
    {s0, s1, s2} = 3'h5;
    tpb = 1'b1;
    tpc = 1'b1;
    {cp_all, imatch, match, nomatch} = 4'h3;
    tx_data = 8'h00;
    tx_last = 1'b0;
    tx_valid = 1'b0;
    wrap_req = 1'b0;
    for (int i = 0; i < 4; i++) begin
      do_reset(codes[i]);
      chk(net_mode, modes[i]);
      if (i == 0) begin
        push(8'h01, 1'b0);
        push(8'h02, 1'b1);
        tx_valid = 1'b0;
        chk(tx_ready, 1'b0);
        repeat (40) @(negedge clk);
        chk(txen, 1'b0);
      end
    end
    done("strap");
    chk({ring, ring_oe, in_pu, test_pu}, 16'h0f);
    wrap_req = 1'b1;
    @(negedge clk);
    chk({wrap, wrap_oe}, 16'h3);
    wrap_req = 1'b0;
    @(negedge clk);
    chk({wrap, wrap_oe}, 16'h1);
    done("pins");
    xcvr.tx_bits.delete();
    push(8'ha5, 1'b0);
    push(8'h3c, 1'b1);
    tx_valid = 1'b0;
    for (n = 0; n < 3000 && xcvr.tx_bits.size() < 16; n++) @(negedge clk);
    bound(3000);
    repeat (20) @(negedge clk);
    for (int i = 0; i < 16; i++) got[i] = xcvr.tx_bits[i];
    chk(16'(xcvr.tx_bits.size()), 16'h10);
    chk(got, 16'h3ca5);
    chk({txen, txd_oe, txen_oe}, 16'h3);
    done("transmit");
    for (int i = 0; i < 6; i++) begin
      {cp_all, imatch, match, nomatch} = cases[i][5:2];
      rxq.delete();
      fe0 = fe_cnt;
      xcvr.send_frame(8'h5a ^ 8'(i));
      for (n = 0; n < 100 && fe_cnt == fe0; n++) @(negedge clk);
      bound(100);
      @(negedge clk);
      chk({copy_frame, arfc}, 16'(cases[i][1:0]));
      chk(16'(rxq.size()), 16'h1);
      chk(rxq[0], 8'h5a ^ 8'(i));
    end
    {cp_all, imatch, match, nomatch} = 4'h3;
    done("receive");
    xcvr.tx_bits.delete();
    c0 = coll_cnt;
    push(8'h11, 1'b0);
    push(8'h22, 1'b0);
    push(8'h33, 1'b1);
    tx_valid = 1'b0;
    xcvr.coll_pulse(3);
    repeat (40) @(negedge clk);
    chk(coll_cnt > c0, 1'b1);
    chk(txen, 1'b0);
    chk(xcvr.tx_bits.size() < 24, 1'b1);
    c0 = coll_cnt;
    xcvr.coll_pulse(3);
    repeat (10) @(negedge clk);
    chk(coll_cnt > c0, 1'b1);
    done("collision");
    tpb = 1'b0;
    tpc = 1'b0;
    repeat (4) @(negedge clk);
    chk({txd_oe, txen_oe, wrap_oe, ring_oe, in_pu, test_pu}, 16'h01);
    tpb = 1'b1;
    tpc = 1'b1;
    repeat (4) @(negedge clk);
    chk({txd_oe, txen_oe, wrap_oe, ring_oe, in_pu}, 16'h1f);
    done("test mode");
    close_out;
  end
endmodule
